// File: hw/sfhi_pkg.sv
package sfhi_pkg;
    // ----------------------------------------
    // opcodes seen by the front end
    // ----------------------------------------
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam logic [7:0] OP_WORD_QUAD = 8'hE7;
    localparam logic [7:0] OP_OCTAL_QUAD = 8'hE3;
    localparam logic [7:0] OP_ENTER_FOUR = 8'h38;
    localparam logic [7:0] OP_EXIT_FOUR = 8'hFF;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TRST_US = 30;
    localparam int TRST_CYC = (TRST_US * 1000000) / CLK_PERIOD_PS;
    localparam int BUSY_CNT_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int BYTE_BITS = 8;

    typedef enum logic [1:0] {SFHI_W1, SFHI_W2, SFHI_W4} sfhi_width_t;

    typedef struct packed {
        logic opcode;
        logic [7:0] data;
    } sfhi_rx_t;
endpackage

// File: hw/sfhi_sync.sv
`timescale 1ns/1ps
module sfhi_sync #(
    parameter int N = 1,
    parameter logic [N-1:0] RST_VAL = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [N-1:0] d_i,
    output logic [N-1:0] q_o
);
    logic [N-1:0] stage1;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stage1 <= RST_VAL;
            q_o <= RST_VAL;
        end else if (ce_i) begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule

// File: hw/sfhi_fifo.sv
`timescale 1ns/1ps
module sfhi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign do_wr = ce_i && in_valid_i && in_ready_o;
    assign do_rd = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// File: hw/sfhi_top.sv
`timescale 1ns/1ps
// Overview of operation
// - chip select high: deselected, lanes floating
// - after power-up, a frame starts only on a chip select fall after a high level
// - single lane: sample input on rising edge
// - single lane: drive output on falling edge
// - dual/quad: lanes bidirectional, sample rise, drive fall
// - quad needs enable bit; pins become lanes
// - write-protect low refuses status register writes while quad enable is clear
// - pause low: float output, ignore clock, input
// - lane 3 is pause or reset without quad
// - dedicated reset pin resets in any pin configuration, but only while ce_i is high
// - clock modes 0 and 3 supported
// - dual read opcodes use lanes 0 and 1 in serial instruction mode
// - quad read opcodes use all four lanes
// - enter/exit commands switch instruction mode
// - four-lane opcode two clocks, serial eight
// - reset leaves serial instruction mode active
// - four-lane entry needs quad enable bit
// - select bit: clear pause, set reset
// - reset-enable then reset; busy while reinitialising
// - pause begins/ends with clock low only
module sfhi_top #(
    parameter int TRST_CYCLES = sfhi_pkg::TRST_CYC,
    parameter int FIFO_DEPTH = sfhi_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] data_lane_i,
    output logic [3:0] data_lane_o,
    output logic [3:0] data_lane_oe_o,
    input wire logic reset_pin_n_i,
    input wire logic quad_io_enable_i,
    input wire logic pause_reset_select_i,
    output logic status_write_refused_o,
    output logic four_lane_instruction_mode_o,
    output logic busy_o,
    output logic paused_o,
    output logic overrun_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output sfhi_pkg::sfhi_rx_t rx_data_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    typedef struct packed {
        logic cs_q;
        logic sclk_q;
        logic armed;
        logic frame;
        logic paused;
        logic four_lane_instruction_mode;
        logic rst_en;
        logic busy;
        logic first;
        logic drop;
        logic drive;
        logic overrun;
        logic push;
        logic push_op;
        logic [sfhi_pkg::BUSY_CNT_W-1:0] busy_cnt;
        sfhi_pkg::sfhi_width_t rxw;
        sfhi_pkg::sfhi_width_t txw;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic [3:0] rx_cnt;
        logic [3:0] tx_cnt;
        logic [3:0] lane_out;
    } sfhi_state_t;

    sfhi_state_t st;
    sfhi_state_t next_st;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [6:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic [3:0] lane_s;
    logic rpin_n_s;

    // select and clock start at their idle-low value so that neither a false arm
    // nor a false clock edge follows reset; the active-low pins start released
    sfhi_sync #(.N(7), .RST_VAL(7'h4C)) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({reset_pin_n_i, cs_n_i, sclk_i, data_lane_i}),
        .q_o(pins_s)
    );
    assign {rpin_n_s, cs_s, sclk_s, lane_s} = pins_s;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] lane_bits(input sfhi_pkg::sfhi_width_t w);
        unique case (w)
            sfhi_pkg::SFHI_W1: lane_bits = 4'h1;
            sfhi_pkg::SFHI_W2: lane_bits = 4'h2;
            sfhi_pkg::SFHI_W4: lane_bits = 4'h4;
            default: lane_bits = 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input sfhi_pkg::sfhi_width_t w);
        unique case (w)
            sfhi_pkg::SFHI_W1: lane_mask = 4'h2;
            sfhi_pkg::SFHI_W2: lane_mask = 4'h3;
            sfhi_pkg::SFHI_W4: lane_mask = 4'hF;
            default: lane_mask = 4'h0;
        endcase
    endfunction

    function automatic logic is_quad(input logic [7:0] op);
        is_quad = (op == sfhi_pkg::OP_QUAD_OUT) || (op == sfhi_pkg::OP_QUAD_IO) ||
            (op == sfhi_pkg::OP_WORD_QUAD) || (op == sfhi_pkg::OP_OCTAL_QUAD);
    endfunction

    // ----------------------------------------
    // pin functions
    // ----------------------------------------
    logic qe;
    logic hold_fn;
    logic hold_req;
    logic pin_rst;
    logic rise;
    logic fall;
    logic active;
    logic fifo_in_ready;

    assign qe = quad_io_enable_i;
    assign hold_fn = !qe && !pause_reset_select_i;
    assign hold_req = hold_fn && !lane_s[3];
    // dedicated pin ignores the enable bits; lane 3 only when configured as reset
    assign pin_rst = !rpin_n_s || (!qe && pause_reset_select_i && !lane_s[3]);
    assign rise = sclk_s && !st.sclk_q;
    assign fall = !sclk_s && st.sclk_q;
    assign active = st.frame && !cs_s && !st.paused && !st.drop;
    assign status_write_refused_o = !qe && !lane_s[2];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic [7:0] in_byte;
    logic [3:0] rx_n;
    logic [3:0] tx_n;
    logic sw_rst;

    always_comb begin
        next_st = st;
        sw_rst = 1'b0;
        rx_n = lane_bits(st.rxw);
        tx_n = lane_bits(st.txw);
        in_byte = st.rx_sh;
        tx_ready_o = 1'b0;
        next_st.push = 1'b0;
        next_st.cs_q = cs_s;
        next_st.sclk_q = sclk_s;
        if (st.push && !fifo_in_ready) begin
            next_st.overrun = 1'b1;
        end
        if (st.busy) begin
            next_st.busy_cnt = st.busy_cnt - 1'b1;
            if (st.busy_cnt == sfhi_pkg::BUSY_CNT_W'(1)) begin
                next_st.busy = 1'b0;
            end
        end
        if (cs_s) begin
            next_st.armed = 1'b1;
            next_st.frame = 1'b0;
            next_st.paused = 1'b0;
            next_st.drive = 1'b0;
        end else if (st.cs_q) begin
            // a select without a prior high level, or while busy, is ignored
            if (st.armed && !st.busy) begin
                next_st.frame = 1'b1;
                next_st.first = 1'b1;
                next_st.drop = 1'b0;
                next_st.rx_cnt = 4'h0;
                next_st.tx_cnt = 4'h0;
                next_st.drive = 1'b0;
                next_st.rxw = st.four_lane_instruction_mode ? sfhi_pkg::SFHI_W4 : sfhi_pkg::SFHI_W1;
                next_st.txw = next_st.rxw;
            end
        end else if (st.frame) begin
            if (!sclk_s) begin
                next_st.paused = hold_req;
            end
            if (rise && active && !st.drive) begin
                unique case (st.rxw)
                    sfhi_pkg::SFHI_W1: in_byte = {st.rx_sh[6:0], lane_s[0]};
                    sfhi_pkg::SFHI_W2: in_byte = {st.rx_sh[5:0], lane_s[1:0]};
                    sfhi_pkg::SFHI_W4: in_byte = {st.rx_sh[3:0], lane_s};
                    default: in_byte = st.rx_sh;
                endcase
                next_st.rx_sh = in_byte;
                next_st.rx_cnt = st.rx_cnt + rx_n;
                if (next_st.rx_cnt >= 4'(sfhi_pkg::BYTE_BITS)) begin
                    next_st.rx_cnt = 4'h0;
                    next_st.push = 1'b1;
                    next_st.push_op = st.first;
                    if (st.first) begin
                        next_st.first = 1'b0;
                        next_st.rst_en = (in_byte == sfhi_pkg::OP_RESET_ENABLE);
                        if (is_quad(in_byte) && !qe) begin
                            next_st.drop = 1'b1;
                            next_st.push = 1'b0;
                        end else if (in_byte == sfhi_pkg::OP_ENTER_FOUR) begin
                            next_st.four_lane_instruction_mode = qe;
                        end else if (in_byte == sfhi_pkg::OP_EXIT_FOUR) begin
                            next_st.four_lane_instruction_mode = 1'b0;
                        end else if (in_byte == sfhi_pkg::OP_RESET) begin
                            sw_rst = st.rst_en;
                        end
                        if (!st.four_lane_instruction_mode) begin
                            unique case (in_byte)
                                sfhi_pkg::OP_DUAL_OUT: next_st.txw = sfhi_pkg::SFHI_W2;
                                sfhi_pkg::OP_DUAL_IO: begin
                                    next_st.rxw = sfhi_pkg::SFHI_W2;
                                    next_st.txw = sfhi_pkg::SFHI_W2;
                                end
                                sfhi_pkg::OP_QUAD_OUT: next_st.txw = sfhi_pkg::SFHI_W4;
                                sfhi_pkg::OP_QUAD_IO, sfhi_pkg::OP_WORD_QUAD,
                                sfhi_pkg::OP_OCTAL_QUAD: begin
                                    next_st.rxw = sfhi_pkg::SFHI_W4;
                                    next_st.txw = sfhi_pkg::SFHI_W4;
                                end
                                default: begin
                                    next_st.rxw = sfhi_pkg::SFHI_W1;
                                    next_st.txw = sfhi_pkg::SFHI_W1;
                                end
                            endcase
                        end
                    end
                end
            end
            if (fall && active) begin
                if (st.tx_cnt != 4'h0) begin
                    next_st.tx_sh = st.tx_sh << tx_n;
                    next_st.tx_cnt = st.tx_cnt - tx_n;
                    // top nibble after the shift, so a four-lane byte sends its low half
                    next_st.lane_out = next_st.tx_sh[7:4];
                end else if (tx_valid_i && !st.first) begin
                    tx_ready_o = 1'b1;
                    next_st.drive = 1'b1;
                    next_st.tx_sh = tx_data_i;
                    next_st.tx_cnt = 4'(sfhi_pkg::BYTE_BITS) - tx_n;
                    next_st.lane_out = tx_data_i[7:4];
                end else begin
                    next_st.drive = 1'b0;
                end
            end
        end
        if (!qe) begin
            next_st.four_lane_instruction_mode = 1'b0;
        end
        if (sw_rst || pin_rst) begin
            next_st = '0;
            next_st.cs_q = cs_s;
            next_st.sclk_q = sclk_s;
            next_st.busy = sw_rst;
            next_st.busy_cnt = sfhi_pkg::BUSY_CNT_W'(TRST_CYCLES);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // lane outputs
    // ----------------------------------------
    logic [3:0] out_map;

    // single lane drives lane 1 only; wider modes use the top bits in lane order
    always_comb begin
        unique case (st.txw)
            sfhi_pkg::SFHI_W1: out_map = {2'b00, st.lane_out[3], 1'b0};
            sfhi_pkg::SFHI_W2: out_map = {2'b00, st.lane_out[3:2]};
            sfhi_pkg::SFHI_W4: out_map = st.lane_out;
            default: out_map = 4'h0;
        endcase
    end

    assign data_lane_o = out_map;
    assign data_lane_oe_o = (st.drive && st.frame && !cs_s && !st.paused) ?
        lane_mask(st.txw) : 4'h0;
    assign four_lane_instruction_mode_o = st.four_lane_instruction_mode;
    assign busy_o = st.busy;
    assign paused_o = st.paused;
    assign overrun_o = st.overrun;

    // ----------------------------------------
    // received byte queue
    // ----------------------------------------
    sfhi_fifo #(.WIDTH($bits(sfhi_pkg::sfhi_rx_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(st.push),
        .in_ready_o(fifo_in_ready),
        .in_data_i({st.push_op, st.rx_sh}),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    deselect_float_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cs_s && $past(cs_s) && $past(ce_i) |-> data_lane_oe_o == 4'h0 && !st.drive)
        else $error("lanes driven while deselected");
    select_armed_a: assert property (@(posedge clock_i) disable iff (rst_i)
        st.frame |-> st.armed)
        else $error("frame began before chip select high seen");
    single_sample_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        rise && active && !st.drive && st.rxw == sfhi_pkg::SFHI_W1 && !pin_rst && !sw_rst
        |=> st.rx_sh[0] == $past(lane_s[0]))
        else $error("serial input not captured on rising edge");
    out_on_fall_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        st.lane_out != $past(st.lane_out) |-> $past(fall) || $past(pin_rst || sw_rst))
        else $error("output changed off a falling edge");
    quad_needs_qe_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        !qe ##1 !qe |-> !st.four_lane_instruction_mode)
        else $error("four-lane mode held without quad enable");
    pause_float_a: assert property (@(posedge clock_i) disable iff (rst_i)
        st.paused |-> data_lane_oe_o == 4'h0 && !tx_ready_o)
        else $error("output active during pause");
    pause_start_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        st.frame && !cs_s && !sclk_s && hold_req && !pin_rst |=> st.paused)
        else $error("pause not taken with clock low");
    pause_hold_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        st.frame && !cs_s && sclk_s && !pin_rst |=> st.paused == $past(st.paused))
        else $error("pause changed while clock high");
    qpi_entry_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(st.four_lane_instruction_mode) |-> $past(qe) && $past(st.frame))
        else $error("four-lane entry without quad enable");
    busy_block_a: assert property (@(posedge clock_i) disable iff (rst_i || !ce_i)
        $rose(st.busy) |-> !st.four_lane_instruction_mode ##1 (st.busy && !st.frame) [*8])
        else $error("commands taken during software reset");
endmodule

// File: verif/sfhi_host_model.sv
`timescale 1ns/1ps
module sfhi_host_model #(
    parameter int HALF_NS = 32
) (
    input wire logic clock_i,
    input wire logic wp_n_i,
    input wire logic pause_n_i,
    input wire logic [3:0] dev_lane_i,
    input wire logic [3:0] dev_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] lane_o
);
    logic [3:0] host_d = 4'h0;
    logic [3:0] host_oe = 4'h0;
    logic junk = 1'b0;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // released lanes 0 and 1 toggle so a stale bit never passes for read data; lanes 2 and 3 carry write-protect and pause
    always @(posedge clock_i) junk <= ~junk;
    assign lane_o = (dev_oe_i & dev_lane_i) | (~dev_oe_i & host_oe & host_d)
        | (~dev_oe_i & ~host_oe & {pause_n_i, wp_n_i, junk, ~junk});
    // only used to break the power-up select order on purpose
    task automatic select_early();
        cs_n_o = 1'b0;
    endtask
    task automatic open_frame(input logic cpol);
        sclk_o = cpol;
        #HALF_NS;
        cs_n_o = 1'b0;
        #HALF_NS;
    endtask
    task automatic shift(input int w, input int n, input logic drv, input logic [7:0] dout,
        output logic [7:0] din);
        logic [7:0] sh;
        logic [3:0] m;
        sh = dout;
        din = 8'h00;
        m = 4'((1 << w) - 1);
        for (int k = 0; k < n; k++) begin
            sclk_o = 1'b0;
            host_oe = drv ? m : 4'h0;
            host_d = sh[7:4] >> (4 - w);
            sh = sh << w;
            #HALF_NS;
            sclk_o = 1'b1;
            din = (din << w) | 8'((w == 1) ? {3'h0, lane_o[1]} : lane_o & m);
            #HALF_NS;
        end
    endtask
    task automatic close_frame(input logic cpol);
        sclk_o = cpol;
        host_oe = 4'h0;
        #HALF_NS;
        cs_n_o = 1'b1;
        #(5 * HALF_NS);
    endtask
    task automatic pulses(input int n);
        sclk_o = 1'b0;
        #HALF_NS;
        for (int k = 0; k < n; k++) begin
            sclk_o = 1'b1;
            #HALF_NS;
            sclk_o = 1'b0;
            #HALF_NS;
        end
    endtask
endmodule

// File: verif/serial_flash_host_interface_tb_top.sv
`timescale 1ns/1ps
module serial_flash_host_interface_tb_top;
    typedef struct packed {
        logic cp;
        logic qe;
        logic [2:0] w;
        logic [7:0] op;
        logic push;
        logic mode;
    } sfhi_row_t;
    localparam int TRST = 400;
    localparam sfhi_row_t ROWS [10] = '{
        '{1'h0, 1'h0, 3'h1, 8'hA5, 1'h1, 1'h0},
        '{1'h1, 1'h0, 3'h1, 8'h5A, 1'h1, 1'h0},
        '{1'h0, 1'h0, 3'h1, sfhi_pkg::OP_QUAD_OUT, 1'h0, 1'h0},
        '{1'h0, 1'h0, 3'h1, sfhi_pkg::OP_QUAD_IO, 1'h0, 1'h0},
        '{1'h1, 1'h0, 3'h1, sfhi_pkg::OP_WORD_QUAD, 1'h0, 1'h0},
        '{1'h0, 1'h0, 3'h1, sfhi_pkg::OP_OCTAL_QUAD, 1'h0, 1'h0},
        '{1'h0, 1'h0, 3'h1, sfhi_pkg::OP_ENTER_FOUR, 1'h1, 1'h0},
        '{1'h1, 1'h1, 3'h1, sfhi_pkg::OP_ENTER_FOUR, 1'h1, 1'h1},
        '{1'h0, 1'h1, 3'h4, 8'hC3, 1'h1, 1'h1},
        '{1'h1, 1'h1, 3'h4, sfhi_pkg::OP_EXIT_FOUR, 1'h1, 1'h0}
    };
    localparam logic [7:0] TXOP [3] = '{8'h0B, sfhi_pkg::OP_DUAL_OUT, sfhi_pkg::OP_QUAD_OUT};
    localparam int TXW [3] = '{1, 2, 4};
    localparam logic [3:0] TXOE [3] = '{4'h2, 4'h3, 4'hF};
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic qe = 1'b0;
    logic sel = 1'b0;
    logic wp_n = 1'b1;
    logic hold_n = 1'b1;
    logic rpin_n = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic cs_n, sclk, refused, four_mode, busy, paused, overrun, rx_valid, tx_ready;
    logic [3:0] lane_in, lane_out, lane_oe;
    logic [7:0] d;
    sfhi_pkg::sfhi_rx_t rx_data;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    always #2.5 clock_i = ~clock_i;
    sfhi_host_model sfhi_host_model_inst (
        .clock_i(clock_i),
        .wp_n_i(wp_n),
        .pause_n_i(hold_n),
        .dev_lane_i(lane_out),
        .dev_oe_i(lane_oe),
        .cs_n_o(cs_n),
        .sclk_o(sclk),
        .lane_o(lane_in)
    );
    sfhi_top #(
        .TRST_CYCLES(TRST),
        .FIFO_DEPTH(8)
    ) sfhi_top_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce),
        .cs_n_i(cs_n),
        .sclk_i(sclk),
        .data_lane_i(lane_in),
        .data_lane_o(lane_out),
        .data_lane_oe_o(lane_oe),
        .reset_pin_n_i(rpin_n),
        .quad_io_enable_i(qe),
        .pause_reset_select_i(sel),
        .status_write_refused_o(refused),
        .four_lane_instruction_mode_o(four_mode),
        .busy_o(busy),
        .paused_o(paused),
        .overrun_o(overrun),
        .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready),
        .rx_data_o(rx_data),
        .tx_valid_i(tx_valid),
        .tx_data_i(tx_data),
        .tx_ready_o(tx_ready)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic frame(input logic cp, input int w, input logic [7:0] op);
        sfhi_host_model_inst.open_frame(cp);
        sfhi_host_model_inst.shift(w, 8 / w, 1'b1, op, d);
        sfhi_host_model_inst.close_frame(cp);
    endtask
    task automatic pop(input logic [8:0] exp, input logic present);
        int k;
        k = 0;
        // never look at the queue in the time step of the edge that pops it
        settle(1);
        while (rx_valid !== 1'b1 && k < 40) begin
            settle(1);
            k++;
        end
        chk_bit(rx_valid, present);
        if (present) begin
            chk_vec(rx_data, exp);
            @(posedge clock_i) rx_ready <= 1'b1;
            @(posedge clock_i) rx_ready <= 1'b0;
        end
    endtask
    // the byte is handed over once; keeping valid up would queue a second copy
    always @(posedge clock_i) if (tx_ready === 1'b1) tx_valid <= 1'b0;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            test_done();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        #1;
        sfhi_host_model_inst.select_early();
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        settle(1);
        chk_vec({5'h00, lane_oe}, 9'h000);
        chk_bit(four_mode, 1'b0);
        chk_bit(busy, 1'b0);
        chk_bit(overrun, 1'b0);
        sfhi_host_model_inst.shift(1, 8, 1'b1, 8'hA5, d);
        sfhi_host_model_inst.close_frame(1'b0);
        pop(9'h000, 1'b0);
        foreach (ROWS[i]) begin
            @(posedge clock_i) qe <= ROWS[i].qe;
            settle(2);
            frame(ROWS[i].cp, int'(ROWS[i].w), ROWS[i].op);
            pop({1'b1, ROWS[i].op}, ROWS[i].push);
            chk_bit(four_mode, ROWS[i].mode);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clock_i) tx_data <= 8'h96 ^ {k[1:0], 6'h00};
            tx_valid <= 1'b1;
            sfhi_host_model_inst.open_frame(1'b0);
            sfhi_host_model_inst.shift(1, 8, 1'b1, TXOP[k], d);
            sfhi_host_model_inst.shift(TXW[k], 8 / TXW[k], 1'b0, 8'h00, d);
            chk_vec({5'h00, lane_oe}, {5'h00, TXOE[k]});
            sfhi_host_model_inst.close_frame(1'b0);
            chk_vec({1'b0, d}, {1'b0, 8'h96 ^ {k[1:0], 6'h00}});
            chk_vec({5'h00, lane_oe}, 9'h000);
            pop({1'b1, TXOP[k]}, 1'b1);
        end
        sfhi_host_model_inst.open_frame(1'b0);
        sfhi_host_model_inst.shift(1, 8, 1'b1, sfhi_pkg::OP_DUAL_IO, d);
        sfhi_host_model_inst.shift(2, 4, 1'b1, 8'h3C, d);
        sfhi_host_model_inst.close_frame(1'b0);
        pop({1'b1, sfhi_pkg::OP_DUAL_IO}, 1'b1);
        pop(9'h03C, 1'b1);
        @(posedge clock_i) wp_n <= 1'b0;
        settle(4);
        chk_bit(refused, 1'b0);
        @(posedge clock_i) qe <= 1'b0;
        settle(4);
        chk_bit(refused, 1'b1);
        @(posedge clock_i) wp_n <= 1'b1;
        sfhi_host_model_inst.open_frame(1'b0);
        sfhi_host_model_inst.shift(1, 4, 1'b1, 8'hA5, d);
        sfhi_host_model_inst.pulses(0);
        @(posedge clock_i) hold_n <= 1'b0;
        settle(4);
        chk_bit(paused, 1'b1);
        sfhi_host_model_inst.pulses(3);
        @(posedge clock_i) hold_n <= 1'b1;
        settle(4);
        chk_bit(paused, 1'b0);
        sfhi_host_model_inst.shift(1, 4, 1'b1, 8'h50, d);
        sfhi_host_model_inst.close_frame(1'b0);
        pop(9'h1A5, 1'b1);
        @(posedge clock_i) qe <= 1'b1;
        settle(2);
        frame(1'b0, 1, sfhi_pkg::OP_ENTER_FOUR);
        pop({1'b1, sfhi_pkg::OP_ENTER_FOUR}, 1'b1);
        frame(1'b0, 4, sfhi_pkg::OP_RESET_ENABLE);
        pop({1'b1, sfhi_pkg::OP_RESET_ENABLE}, 1'b1);
        frame(1'b0, 4, sfhi_pkg::OP_RESET);
        chk_bit(busy, 1'b1);
        chk_bit(four_mode, 1'b0);
        frame(1'b0, 1, 8'hA5);
        pop(9'h000, 1'b0);
        n = 0;
        while (busy === 1'b1 && n < TRST) begin
            settle(1);
            n++;
        end
        chk_bit(busy, 1'b0);
        @(posedge clock_i) qe <= 1'b0;
        sel <= 1'b1;
        frame(1'b0, 1, sfhi_pkg::OP_RESET_ENABLE);
        pop({1'b1, sfhi_pkg::OP_RESET_ENABLE}, 1'b1);
        frame(1'b0, 1, sfhi_pkg::OP_RESET);
        chk_bit(busy, 1'b1);
        @(posedge clock_i) hold_n <= 1'b0;
        settle(4);
        chk_bit(busy, 1'b0);
        @(posedge clock_i) hold_n <= 1'b1;
        qe <= 1'b1;
        settle(4);
        frame(1'b0, 1, sfhi_pkg::OP_ENTER_FOUR);
        pop({1'b1, sfhi_pkg::OP_ENTER_FOUR}, 1'b1);
        @(posedge clock_i) hold_n <= 1'b0;
        settle(4);
        chk_bit(four_mode, 1'b1);
        @(posedge clock_i) rpin_n <= 1'b0;
        ce <= 1'b0;
        settle(4);
        chk_bit(four_mode, 1'b1);
        @(posedge clock_i) ce <= 1'b1;
        settle(4);
        chk_bit(four_mode, 1'b0);
        @(posedge clock_i) rpin_n <= 1'b1;
        hold_n <= 1'b1;
        settle(4);
        for (int k = 0; k < 9; k++) frame(1'b0, 1, 8'h10 + 8'(k));
        chk_bit(overrun, 1'b1);
        for (int k = 0; k < 8; k++) pop({1'b1, 8'h10 + 8'(k)}, 1'b1);
        pop(9'h000, 1'b0);
        test_done();
    end
endmodule
